// ==== src/osd_defines.vh ====
// shared constants for the original size detector
`ifndef OSD_DEFINES_VH
`define OSD_DEFINES_VH
// size codes reported on sizeCode
`define OSD_SIZE_NONE 4'h0
`define OSD_SIZE_A3 4'h1
`define OSD_SIZE_A4 4'h2
`define OSD_SIZE_B4 4'h3
`define OSD_SIZE_B5 4'h4
`define OSD_SIZE_A4R 4'h5
`define OSD_SIZE_A5 4'h6
`define OSD_SIZE_B5R 4'h7
`define OSD_SIZE_A5R 4'h8
`define OSD_SIZE_LD 4'h9
`define OSD_SIZE_LT 4'ha
`define OSD_SIZE_LG 4'hb
`define OSD_SIZE_LTR 4'hc
`define OSD_SIZE_ST 4'hd
`define OSD_SIZE_STR 4'he
// sensor vector bit positions {center,rear,one,two,three}
`define OSD_BIT_CENTER 4
`define OSD_BIT_REAR 3
`define OSD_BIT_ONE 2
`define OSD_BIT_TWO 1
`define OSD_BIT_THREE 0
`define OSD_RESET_SIZE 4'h0
`endif

// ==== src/osd_sync2.v ====
// two flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module osd_sync2 #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_r;
  // first stage feeds only the second stage
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule // osd_sync2

// ==== src/osd_size_detector.v ====
// original size detector: sensor pattern decode, hold and change event
`timescale 1ns/1ns
`include "osd_defines.vh"
module osd_size_detector (
  input wire ref_clk,
  input wire rst,
  input wire inchSeries,
  input wire detectMode,
  input wire carriageHome,
  input wire reflect_sensor_center,
  input wire reflect_sensor_rear,
  input wire reflect_sensor_one,
  input wire reflect_sensor_two,
  input wire reflect_sensor_three,
  input wire platen_cover_sensor,
  output reg [3:0] sizeCode,
  output reg sizeValid,
  output reg sizeChanged,
  output reg carriageMoveReq
);
  wire [5:0] pinSync;
  wire [4:0] pat;
  wire coverOn;
  reg [3:0] decoded;
  reg hit;
  reg [3:0] sizeNxt;

  // pins are asynchronous to ref_clk, so both stages run before decoding
  osd_sync2 #(.WIDTH(6)) uSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn({platen_cover_sensor, reflect_sensor_center, reflect_sensor_rear,
      reflect_sensor_one, reflect_sensor_two, reflect_sensor_three}),
    .syncOut(pinSync)
  );
  assign coverOn = pinSync[5];
  assign pat = pinSync[4:0];

  // table decode; the sensors own the pulse echo check, a 0 here means present
  always @* begin
    decoded = `OSD_SIZE_NONE;
    hit = 1'b0;
    if (!inchSeries) begin
      hit = 1'b1;
      case (pat)
        5'h00: decoded = `OSD_SIZE_A3;
        5'h08: decoded = `OSD_SIZE_A4;
        5'h02: decoded = `OSD_SIZE_B4;
        5'h1a: decoded = `OSD_SIZE_B5;
        5'h06: decoded = `OSD_SIZE_A4R;
        5'h1e: decoded = `OSD_SIZE_A5;
        5'h07: decoded = `OSD_SIZE_B5R;
        5'h0f: decoded = `OSD_SIZE_A5R;
        5'h1f: decoded = `OSD_SIZE_NONE;
        default: hit = 1'b0;
      endcase
    end else begin
      // sensor one is not fitted in this variant and is ignored
      hit = 1'b1;
      case ({pat[`OSD_BIT_CENTER], pat[`OSD_BIT_REAR], pat[`OSD_BIT_TWO], pat[`OSD_BIT_THREE]})
        4'h0: decoded = `OSD_SIZE_LD;
        4'h4: decoded = `OSD_SIZE_LT;
        4'h2: decoded = `OSD_SIZE_LG;
        4'h6: decoded = `OSD_SIZE_LTR;
        4'he: decoded = `OSD_SIZE_ST;
        4'h7: decoded = `OSD_SIZE_STR;
        4'hf: decoded = `OSD_SIZE_NONE;
        default: hit = 1'b0;
      endcase
    end
  end

  // update only with cover off in detect mode at home; otherwise hold
  always @* begin
    sizeNxt = sizeCode;
    if (!coverOn && detectMode && carriageHome && hit) begin
      sizeNxt = decoded;
    end
    // unmatched pattern or cover on keeps the previous value
  end

  // result register and change pulse
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sizeCode <= `OSD_RESET_SIZE;
      sizeValid <= 1'b0;
      sizeChanged <= 1'b0;
      carriageMoveReq <= 1'b0;
    end else begin
      sizeCode <= sizeNxt;
      sizeValid <= (sizeNxt != `OSD_SIZE_NONE);
      sizeChanged <= (sizeNxt != sizeCode);
      carriageMoveReq <= 1'b0;
    end
  end
endmodule // osd_size_detector

// ==== bench/osd_checker_properties.sv ====
// assertions on the size detector ports
`timescale 1ns/1ns
module osd_checker (input ref_clk, rst, detectMode, carriageHome, platen_cover_sensor,
  input [3:0] sizeCode, input sizeValid, sizeChanged, carriageMoveReq);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_no_move: assert property (!carriageMoveReq) else $error("move");
  a_valid_code: assert property (sizeValid == (sizeCode != 4'h0)) else $error("valid");
  a_pulse_cause: assert property (sizeChanged |-> $changed(sizeCode)) else $error("pulse");
  a_change_pulse: assert property ($changed(sizeCode) |-> sizeChanged) else $error("no pulse");
  a_cover_hold: assert property (platen_cover_sensor |-> ##3 $stable(sizeCode)) else $error("cover");
  a_mode_hold: assert property (!detectMode |=> $stable(sizeCode)) else $error("mode");
  a_home_hold: assert property (!carriageHome |=> $stable(sizeCode)) else $error("home");
  a_reset_none: assert property ($fell(rst) |-> sizeCode == 4'h0 [*3]) else $error("reset");
endmodule // osd_checker

// ==== bench/osd_sensor_model.sv ====
// far side sensors: a pin reads 0 only while its own echo returns
`timescale 1ns/1ns
module osd_sensor_model (input [5:0] pins, output [5:0] sensePins);
  // pulsing and echo matching stay inside each sensor, so levels pass straight on
  assign sensePins = pins;
endmodule // osd_sensor_model

// ==== bench/tb_osd_size_detector.sv ====
// bench for the original size detector
`timescale 1ns/1ns
module tb_osd_size_detector;
  reg ref_clk = 0, rst = 1, inchSeries = 0, detectMode = 1, carriageHome = 1;
  reg [5:0] pins = 6'h3e;
  reg [3:0] last = 4'h0;
  int mismatches = 0, checks_done = 0, cyc = 0;
  wire [5:0] s;
  wire [3:0] sizeCode;
  wire sizeValid, sizeChanged, carriageMoveReq;
  osd_sensor_model osd_sensor_model_i (.pins(pins), .sensePins(s));
  osd_size_detector osd_size_detector_i (.*, .reflect_sensor_center(s[5]), .reflect_sensor_rear(s[4]),
    .reflect_sensor_one(s[3]), .reflect_sensor_two(s[2]), .reflect_sensor_three(s[1]), .platen_cover_sensor(s[0]));
  // clock, and a guard far past the hundred or so cycles of stimulus
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc > 999) finish_test;
  task chk(string n, logic [3:0] v, logic [3:0] e);
    checks_done++;
    if (v !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, v);
    end
  endtask
  task finish_test;
    mismatches += cyc > 999;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // pins cross two sync flops, so the answer is due three edges on
  task ap(logic [5:0] p, logic [1:0] g, logic [3:0] e);
    logic [1:0] pg;
    @(posedge ref_clk);
    pg = {detectMode, carriageHome};
    pins <= p;
    {detectMode, carriageHome} <= g;
    repeat (2) @(posedge ref_clk);
    // with the gate unchanged the old result must still stand while the pins cross the sync flops
    #1 if (pg == g) chk("sizeCode early", sizeCode, last);
    @(posedge ref_clk);
    #1 chk("sizeCode", sizeCode, e);
    chk("sizeChanged", {3'h0, sizeChanged}, {3'h0, e != last});
    chk("sizeValid", {3'h0, sizeValid}, {3'h0, e != 4'h0});
    chk("carriageMoveReq", {3'h0, carriageMoveReq}, 4'h0);
    last = e;
  endtask
  task t_hold;
    ap(6'h10, 2'b11, 4'h2);
    ap(6'h02, 2'b11, 4'h2);
    ap(6'h01, 2'b11, 4'h2);
    ap(6'h00, 2'b01, 4'h2);
    ap(6'h00, 2'b10, 4'h2);
    ap(6'h3e, 2'b11, 4'h0);
    $display("hold test done");
  endtask
  task automatic t_size;
    logic [4:0] m [9] = '{5'h00, 5'h08, 5'h02, 5'h1a, 5'h06, 5'h1e, 5'h07, 5'h0f, 5'h1f};
    logic [3:0] n [7] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'he, 4'h7, 4'hf};
    for (int i = 0; i < 9; i++) ap({m[i], 1'b0}, 2'b11, i < 8 ? 4'(i + 1) : 4'h0);
    @(posedge ref_clk) inchSeries <= 1;
    for (int i = 0; i < 7; i++) ap({n[i][3:2], 1'b1, n[i][1:0], 1'b0}, 2'b11, i < 6 ? 4'(i + 9) : 4'h0);
    $display("size test done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    t_hold;
    t_size;
    finish_test;
  end
endmodule // tb_osd_size_detector
bind osd_size_detector osd_checker osd_checker_i (.*);
